// >>> core/intermittent_fault_stage.sv
// Purpose: control and timing of one intermittent earth-fault stage
// Assumes: spike detection math done outside; inputs synchronous
// Notes: times in 5 ms ticks; settings static, no setting-group input
`timescale 1ns/1ps
module intermittent_fault_stage import ief_pkg::*; #(
    parameter int unsigned period = tick_cycles,
    parameter int sample_width = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [sample_width-1:0] residual_voltage,
    input wire logic [sample_width-1:0] residual_current_ch_a,
    input wire logic [sample_width-1:0] residual_current_ch_b,
    input wire logic sample_valid,
    input wire logic spike_valid,
    input wire logic delta_negative,
    input wire logic [sample_width-1:0] delta_voltage,
    input wire logic [sample_width-1:0] delta_current,
    input wire logic block_in,
    input wire logic [1:0] input_selection,
    input wire logic [2:0] mode_setting,
    input wire logic [2:0] force_setting,
    input wire logic forcing_enable,
    input wire logic [1:0] voltage_channel_select,
    input wire settings_type settings,
    output outs_type outs,
    output logic pickup,
    output logic [2:0] behaviour,
    output logic [2:0] condition,
    output logic [1:0] voltage_in_use,
    output logic [18:0] expected_operate_time,
    output logic [18:0] time_remaining,
    output logic [31:0] spikes_remaining,
    output logic block_display_event,
    output logic block_stamped_event,
    output logic [sample_width-1:0] event_current,
    output logic event_forward
);
    logic tick, block_sampled, blocked_eff, mode_off_now, release_all;
    logic spike_ok, fwd_spike, rev_spike, block_rise, op_done;
    logic fwd_start, rev_start, trip_core, blocked_core;
    logic fwd_running, fwd_expired, rev_running, rev_expired;
    logic op_running, op_expired;
    logic [sample_width-1:0] volt_max, curr_max, curr_sel, curr_peak;
    logic [31:0] fwd_count, rev_count;
    logic [18:0] op_rem;
    logic [1:0] sel_reg;
    mode_type mode_reg;
    force_type force_reg;
    outs_type next_outs;

    ief_tick_gen #(.period(period)) u_tick (.clock(clock), .srst(srst),
        .tick(tick));

    // held here so group switches cannot touch them
    always_ff @(posedge clock) begin
        if (srst) begin
            sel_reg <= sel_ch_a;
            mode_reg <= mode_on;
            force_reg <= force_normal;
        end else begin
            sel_reg <= (input_selection == sel_ch_b) ? sel_ch_b : sel_ch_a;
            case (mode_setting)
                3'h1: mode_reg <= mode_on;
                3'h2: mode_reg <= mode_blocked;
                3'h3: mode_reg <= mode_test;
                3'h4: mode_reg <= mode_test_blocked;
                3'h5: mode_reg <= mode_off;
                default: mode_reg <= mode_reg;
            endcase
            if (force_setting <= 3'h4) begin
                force_reg <= force_type'(force_setting);
            end
        end
    end

    assign curr_sel = (sel_reg == sel_ch_b) ? residual_current_ch_b
                                            : residual_current_ch_a;

    // running maxima of the voltage buffer and the selected current buffer over the tick window
    always_ff @(posedge clock) begin
        if (srst || tick) begin
            volt_max <= '0;
            curr_max <= '0;
        end else if (sample_valid) begin
            if (residual_voltage > volt_max) begin
                volt_max <= residual_voltage;
            end
            if (curr_sel > curr_max) begin
                curr_max <= curr_sel;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pickup <= 1'b0;
            curr_peak <= '0;
        end else if (tick) begin
            pickup <= (volt_max >= settings.voltage_spike_threshold)
                && (curr_max >= settings.current_spike_threshold);
            curr_peak <= curr_max;
        end
    end

    // block taken once per program cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            block_sampled <= 1'b0;
        end else if (tick) begin
            block_sampled <= block_in;
        end
    end

    // blocked modes behave as a held block
    assign blocked_eff = block_sampled || mode_reg == mode_blocked
        || mode_reg == mode_test_blocked;
    assign mode_off_now = (mode_reg == mode_off);

    // spike must beat both delta thresholds
    assign spike_ok = spike_valid
        && delta_voltage > settings.voltage_spike_threshold
        && delta_current > settings.current_spike_threshold;
    // sign of admittance delta gives direction
    assign fwd_spike = spike_ok && delta_negative && !blocked_eff
        && !mode_off_now;
    assign rev_spike = spike_ok && !delta_negative && !blocked_eff
        && !mode_off_now;

    // forward release timer restart per spike
    ief_tick_timer #(.width(19)) u_fwd (.clock(clock), .srst(srst),
        .tick(tick), .load(fwd_spike), .clear(blocked_eff || mode_off_now),
        .length(settings.fwd_release_ticks), .running(fwd_running),
        .expired(fwd_expired), .remaining());

    // reverse release timer restart per spike
    ief_tick_timer #(.width(19)) u_rev (.clock(clock), .srst(srst),
        .tick(tick), .load(rev_spike), .clear(blocked_eff || mode_off_now),
        .length(settings.rev_release_ticks), .running(rev_running),
        .expired(rev_expired), .remaining());

    // a block ends the fault like a dropped pick-up
    // a spike landing on the expiry cycle restarts rather than releases
    assign release_all = (fwd_expired && !fwd_spike) || blocked_eff
        || mode_off_now;

    // operate timer loads at fault onset only
    ief_tick_timer #(.width(19)) u_op (.clock(clock), .srst(srst),
        .tick(tick), .load(fwd_spike && !fwd_start), .clear(release_all),
        .length(settings.operate_ticks), .running(op_running),
        .expired(op_expired), .remaining(op_rem));

    // forward start cleared at release expiry
    always_ff @(posedge clock) begin
        if (srst || release_all) begin
            fwd_start <= 1'b0;
        end else if (fwd_spike) begin
            fwd_start <= 1'b1;
        end
    end

    // reverse start cleared at its expiry
    always_ff @(posedge clock) begin
        if (srst || (rev_expired && !rev_spike) || blocked_eff
            || mode_off_now) begin
            rev_start <= 1'b0;
        end else if (rev_spike) begin
            rev_start <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || (!fwd_running && !fwd_spike)) begin
            fwd_count <= 32'h0;
        end else if (fwd_spike && fwd_count != 32'hffffffff) begin
            fwd_count <= fwd_count + 32'h1;
        end
        if (srst || (!rev_running && !rev_spike)) begin
            rev_count <= 32'h0;
        end else if (rev_spike && rev_count != 32'hffffffff) begin
            rev_count <= rev_count + 32'h1;
        end
    end

    // operate time spent, waiting on spike count
    always_ff @(posedge clock) begin
        if (srst || release_all) begin
            op_done <= 1'b0;
        end else if (op_expired) begin
            op_done <= 1'b1;
        end
    end

    // trip once count exceeds setting after delay
    always_ff @(posedge clock) begin
        if (srst || release_all) begin
            trip_core <= 1'b0;
        end else if ((op_expired || op_done) && fwd_start
                     && fwd_count > settings.trip_spike_count_setting) begin
            trip_core <= 1'b1;
        end
    end

    // pick-up under block only flags blocked
    always_ff @(posedge clock) begin
        if (srst || mode_off_now) begin
            blocked_core <= 1'b0;
        end else begin
            blocked_core <= blocked_eff && (pickup || spike_ok);
        end
    end

    assign block_rise = blocked_core == 1'b0 && blocked_eff
        && (pickup || spike_ok) && !mode_off_now;

    // display and stamped events on blocking
    always_ff @(posedge clock) begin
        if (srst) begin
            block_display_event <= 1'b0;
            block_stamped_event <= 1'b0;
            event_current <= '0;
            event_forward <= 1'b0;
        end else begin
            block_display_event <= block_rise;
            block_stamped_event <= block_rise;
            if (block_rise) begin
                event_current <= curr_peak;
                event_forward <= delta_negative;
            end
        end
    end

    // off mode keeps all four outs bits low
    always_comb begin
        next_outs = '{fwd_start, rev_start, trip_core, blocked_core};
        if (forcing_enable) begin
            case (force_reg)
                force_blocked: next_outs = 4'b0001;
                force_fwd: next_outs = 4'b1000;
                force_rev: next_outs = 4'b0100;
                force_trip: next_outs = 4'b0010;
                default: next_outs = next_outs;
            endcase
        end
        if (mode_off_now) begin
            next_outs = 4'b0000;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            outs <= '0;
        end else begin
            outs <= next_outs;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            behaviour <= 3'(mode_on);
            condition <= 3'(cond_normal);
            voltage_in_use <= 2'(vin_none);
        end else begin
            behaviour <= 3'(mode_reg);
            if (next_outs.trip) begin
                condition <= 3'(cond_trip);
            end else if (next_outs.blocked) begin
                condition <= 3'(cond_blocked);
            end else if (next_outs.forward_start) begin
                condition <= 3'(cond_fwd);
            end else if (next_outs.reverse_start) begin
                condition <= 3'(cond_rev);
            end else begin
                condition <= 3'(cond_normal);
            end
            case (voltage_channel_select)
                2'h1: voltage_in_use <= 2'(vin_third);
                2'h2: voltage_in_use <= 2'(vin_fourth);
                default: voltage_in_use <= 2'(vin_none);
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            expected_operate_time <= 19'h0;
            time_remaining <= 19'h0;
            spikes_remaining <= 32'h0;
        end else begin
            expected_operate_time <= settings.operate_ticks;
            time_remaining <= op_running ? op_rem : 19'h0;
            spikes_remaining <=
                (fwd_count > settings.trip_spike_count_setting) ? 32'h0
                : settings.trip_spike_count_setting - fwd_count + 32'h1;
        end
    end

    // block drops start by the next cycle
    a_block_drops_start: assert property (@(posedge clock) disable iff (srst)
        blocked_eff |=> !fwd_start)
        else $error("start held under block");
    a_off_quiet: assert property (@(posedge clock) disable iff (srst)
        mode_off_now |=> outs == '0)
        else $error("outputs active in off mode");
    a_trip_count: assert property (@(posedge clock) disable iff (srst)
        $rose(trip_core) |-> fwd_count > settings.trip_spike_count_setting)
        else $error("trip below spike count");
    a_fwd_expiry: assert property (@(posedge clock) disable iff (srst)
        fwd_expired && !fwd_spike |=> !fwd_start)
        else $error("forward start survived expiry");
    a_rev_expiry: assert property (@(posedge clock) disable iff (srst)
        rev_expired && !rev_spike |=> !rev_start)
        else $error("reverse start survived expiry");
    a_no_start_blocked: assert property (@(posedge clock)
        disable iff (srst)
        blocked_eff && !fwd_start |=> !fwd_start)
        else $error("start raised under block");
    a_block_sample: assert property (@(posedge clock) disable iff (srst)
        !tick |=> $stable(block_sampled))
        else $error("block sampled off tick");
    a_op_with_start: assert property (@(posedge clock) disable iff (srst)
        op_running |-> fwd_start || $past(fwd_spike))
        else $error("operate timer without start");
endmodule

// >>> core/ief_pkg.sv
// Purpose: shared constants and types for the intermittent fault stage
// Assumes: 125 MHz clock, 5 ms time base
// Notes: tick period in microseconds, converted to a cycle count here
package ief_pkg;
    localparam int unsigned clock_mhz = 125;
    localparam int unsigned tick_us = 5000;
    localparam int unsigned tick_cycles = tick_us * clock_mhz;
    localparam int unsigned block_lead_us = 5000;
    localparam int unsigned fwd_release_default = 60;
    localparam int unsigned rev_release_default = 60;
    localparam int unsigned operate_default = 100;
    localparam int unsigned timer_max = 360000;
    localparam int unsigned spikes_default = 2;
    localparam logic [15:0] voltage_thr_default = 16'h1f40;
    localparam logic [15:0] current_thr_default = 16'h0032;
    localparam logic [1:0] sel_ch_a = 2'h1;
    localparam logic [1:0] sel_ch_b = 2'h2;

    typedef enum logic [2:0] {
        mode_on = 3'h1,
        mode_blocked = 3'h2,
        mode_test = 3'h3,
        mode_test_blocked = 3'h4,
        mode_off = 3'h5
    } mode_type;

    typedef enum logic [2:0] {
        force_normal = 3'h0,
        force_blocked = 3'h1,
        force_fwd = 3'h2,
        force_rev = 3'h3,
        force_trip = 3'h4
    } force_type;

    typedef enum logic [2:0] {
        cond_normal = 3'h0,
        cond_fwd = 3'h1,
        cond_rev = 3'h2,
        cond_trip = 3'h3,
        cond_blocked = 3'h4
    } cond_type;

    typedef enum logic [1:0] {
        vin_none = 2'h0,
        vin_third = 2'h1,
        vin_fourth = 2'h2
    } vin_type;

    typedef struct packed {
        logic [15:0] voltage_spike_threshold;
        logic [15:0] current_spike_threshold;
        logic [18:0] fwd_release_ticks;
        logic [18:0] rev_release_ticks;
        logic [18:0] operate_ticks;
        logic [31:0] trip_spike_count_setting;
    } settings_type;

    typedef struct packed {
        logic forward_start;
        logic reverse_start;
        logic trip;
        logic blocked;
    } outs_type;
endpackage

// >>> core/ief_tick_gen.sv
// Purpose: 5 ms program-cycle strobe
// Assumes: srst synchronous, active high
// Notes: one-cycle pulse every period cycles
`timescale 1ns/1ps
module ief_tick_gen import ief_pkg::*; #(
    parameter int unsigned period = tick_cycles
) (
    input wire logic clock,
    input wire logic srst,
    output logic tick
);
    logic [31:0] count;

    always_ff @(posedge clock) begin
        if (srst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(period - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// >>> core/ief_tick_timer.sv
// Purpose: tick-based countdown timer with restart
// Assumes: load and tick are synchronous to clock
// Notes: expired pulses one cycle when the count reaches zero
`timescale 1ns/1ps
module ief_tick_timer #(
    parameter int width = 19
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic tick,
    input wire logic load,
    input wire logic clear,
    input wire logic [width-1:0] length,
    output logic running,
    output logic expired,
    output logic [width-1:0] remaining
);
    always_ff @(posedge clock) begin
        if (srst || clear) begin
            running <= 1'b0;
            remaining <= '0;
            expired <= 1'b0;
        end else if (load) begin
            running <= 1'b1;
            remaining <= length;
            expired <= 1'b0;
        end else if (running && tick) begin
            if (remaining <= width'(1)) begin
                running <= 1'b0;
                remaining <= '0;
                expired <= 1'b1;
            end else begin
                remaining <= remaining - width'(1);
                expired <= 1'b0;
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule

// >>> sim/matrix_model.sv
// Purpose: blocking matrix and residual sample buffers
// Assumes: one clock, srst synchronous active high
// Notes: data lines show inverted values between valid samples
`timescale 1ns/1ps
module matrix_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic block_req,
    input wire logic [15:0] amp,
    output logic block_in,
    output logic [15:0] residual_voltage,
    output logic [15:0] residual_current_ch_a,
    output logic [15:0] residual_current_ch_b,
    output logic sample_valid
);
    logic [1:0] phase;

    // block leads expiry
    // bench raises block_req whole ticks ahead of the operate delay
    always_ff @(posedge clock) begin
        block_in <= srst ? 1'b0 : block_req;
    end

    // sample buffer feed
    // lines are scrambled off-sample so stale data never looks valid
    always_ff @(posedge clock) begin
        if (srst) begin
            phase <= 2'h0;
            sample_valid <= 1'b0;
            residual_voltage <= 16'h0000;
            residual_current_ch_a <= 16'h0000;
            residual_current_ch_b <= 16'h0000;
        end else begin
            phase <= phase + 2'h1;
            sample_valid <= (phase == 2'h0);
            residual_voltage <= (phase == 2'h0) ? amp : ~amp;
            residual_current_ch_a <= (phase == 2'h0) ? amp >> 1 : ~amp;
            residual_current_ch_b <= (phase == 2'h0) ? amp >> 2 : ~amp;
        end
    end
endmodule

// >>> sim/tb_top.sv
// Purpose: directed test of the intermittent fault stage
// Assumes: tick shortened to 10 cycles, times in ticks
// Notes: waits carry a tick of margin for the unknown tick phase
`timescale 1ns/1ps
module tb_top import ief_pkg::*; ;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic spike_valid = 1'b0;
    logic delta_negative = 1'b0;
    logic block_req = 1'b0;
    logic forcing_enable = 1'b0;
    logic [15:0] dv = 16'h0000;
    logic [15:0] di = 16'h0000;
    logic [15:0] amp = 16'h2000;
    logic [1:0] input_selection = 2'h2;
    logic [1:0] vsel = 2'h0;
    logic [2:0] mode = 3'h1;
    logic [2:0] force_code = 3'h0;
    settings_type s;
    outs_type outs;
    logic pickup, block_display_event, block_stamped_event, event_forward;
    logic [2:0] behaviour, condition;
    logic [1:0] voltage_in_use;
    logic [18:0] expected_operate_time, time_remaining;
    logic [31:0] spikes_remaining;
    logic [15:0] event_current, rv, ra, rb;
    logic block_in, sample_valid;
    int fail_count = 0;
    int checks_done = 0;
    int pulses = 0;
    logic [3:0] force_exp [1:4] = '{4'h1, 4'h8, 4'h4, 4'h2};

    always #4 clock = ~clock;

    always @(posedge clock) begin
        if ((block_display_event & block_stamped_event) === 1'b1) pulses++;
    end

    matrix_model partner (.clock(clock), .srst(srst),
        .block_req(block_req), .amp(amp), .block_in(block_in),
        .residual_voltage(rv), .residual_current_ch_a(ra),
        .residual_current_ch_b(rb), .sample_valid(sample_valid));

    intermittent_fault_stage #(.period(10)) uut (.clock(clock),
        .srst(srst), .residual_voltage(rv), .residual_current_ch_a(ra),
        .residual_current_ch_b(rb), .sample_valid(sample_valid),
        .spike_valid(spike_valid), .delta_negative(delta_negative),
        .delta_voltage(dv), .delta_current(di), .block_in(block_in),
        .input_selection(input_selection), .mode_setting(mode),
        .force_setting(force_code), .forcing_enable(forcing_enable),
        .voltage_channel_select(vsel), .settings(s), .outs(outs),
        .pickup(pickup), .behaviour(behaviour), .condition(condition),
        .voltage_in_use(voltage_in_use),
        .expected_operate_time(expected_operate_time),
        .time_remaining(time_remaining),
        .spikes_remaining(spikes_remaining),
        .block_display_event(block_display_event),
        .block_stamped_event(block_stamped_event),
        .event_current(event_current), .event_forward(event_forward));

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one-cycle spike report with its deltas
    task automatic spike(input logic neg, input logic [15:0] v,
            input logic [15:0] i);
        spike_valid = 1'b1;
        delta_negative = neg;
        dv = v;
        di = i;
        idle(1);
        spike_valid = 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end

    initial begin
        s.voltage_spike_threshold = voltage_thr_default;
        s.current_spike_threshold = current_thr_default;
        s.fwd_release_ticks = 19'h6;
        s.rev_release_ticks = 19'h6;
        s.operate_ticks = 19'h5;
        s.trip_spike_count_setting = 32'h2;
        repeat (5) @(posedge clock);
        #1 srst = 1'b0;
        idle(3);
        chk(behaviour, 32'h1);
        chk({outs, condition}, 32'h0);
        chk(expected_operate_time, 32'h5);
        // deltas equal to a threshold are not above it
        spike(1'b1, 16'h1f40, 16'h0100);
        idle(1);
        spike(1'b1, 16'h2000, 16'h0032);
        idle(3);
        chk(outs, 32'h0);
        spike(1'b1, 16'h2000, 16'h0100);
        idle(2);
        chk({outs, condition}, {4'h8, 3'h1});
        chk(spikes_remaining, 32'h2);
        chk(time_remaining != 0 && time_remaining <= 5, 32'h1);
        idle(25);
        chk(outs.forward_start, 32'h1);
        chk(pickup, 32'h1);
        idle(60);
        chk({outs, condition}, 32'h0);
        spike(1'b0, 16'h2000, 16'h0100);
        idle(3);
        chk({outs, condition}, {4'h4, 3'h2});
        idle(90);
        chk(outs.reverse_start, 32'h0);
        // spikes two ticks apart inside the release time reach trip
        spike(1'b1, 16'h2000, 16'h0100);
        idle(19);
        spike(1'b1, 16'h2000, 16'h0100);
        idle(19);
        spike(1'b1, 16'h2000, 16'h0100);
        idle(35);
        chk({outs.trip, condition}, {1'b1, 3'h3});
        chk(spikes_remaining, 32'h0);
        idle(100);
        chk(outs, 32'h0);
        // one spike: operate time runs out below the count
        spike(1'b1, 16'h2000, 16'h0100);
        idle(57);
        chk(outs.trip, 32'h0);
        idle(40);
        chk(outs, 32'h0);
        spike(1'b1, 16'h2000, 16'h0100);
        idle(10);
        block_req = 1'b1;
        idle(25);
        chk({outs, condition}, {4'h1, 3'h4});
        spike(1'b1, 16'h2000, 16'h0100);
        idle(3);
        chk(outs.forward_start, 32'h0);
        chk(pulses != 0, 32'h1);
        // channel b carries a quarter of the partner amplitude
        chk({event_forward, event_current}, {1'b1, 16'h0800});
        block_req = 1'b0;
        idle(30);
        for (int m = 1; m <= 5; m++) begin
            mode = m[2:0];
            idle(3);
            chk(behaviour, m);
        end
        spike(1'b1, 16'h2000, 16'h0100);
        idle(3);
        chk(outs, 32'h0);
        mode = 3'h2;
        spike(1'b1, 16'h2000, 16'h0100);
        idle(3);
        chk(outs.forward_start, 32'h0);
        mode = 3'h1;
        idle(3);
        force_code = 3'h4;
        idle(3);
        chk(outs.trip, 32'h0);
        forcing_enable = 1'b1;
        for (int f = 1; f <= 4; f++) begin
            force_code = f[2:0];
            idle(3);
            chk(outs, force_exp[f]);
        end
        forcing_enable = 1'b0;
        force_code = 3'h0;
        for (int v = 0; v <= 3; v++) begin
            vsel = v[1:0];
            idle(3);
            chk(voltage_in_use, (v == 3) ? 0 : v);
        end
        amp = 16'h0100;
        idle(25);
        chk(pickup, 32'h0);
        report_and_stop();
    end
endmodule
